/* rtl/serial_port_pkg.sv */
package serial_port_pkg;

    // ---------------------------------------------------------------
    // Register bus and offsets
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_CTRL_ONE = 8'h05;
    localparam logic [7:0] OFF_CTRL_TWO = 8'h06;
    localparam logic [7:0] OFF_DATA = 8'h07;
    localparam logic [7:0] OFF_IF_MODE = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h09;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0A;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int BIT_SAMPLE_PHASE = 7;
    localparam int BIT_COLLISION = 6;
    localparam int BIT_CLK_SEL_LO = 3;
    localparam int BIT_SHIFT_EDGE = 2;
    localparam int BIT_BIT_ORDER = 1;
    localparam int BIT_TX_LOADED = 0;
    localparam int BIT_START_SHIFT = 7;
    localparam int BIT_MODE_LO = 1;
    localparam int BIT_RX_FULL = 0;
    localparam int BIT_IF_MODE_LO = 0;
    localparam int BIT_IRQ_DONE = 0;
    localparam int BIT_IRQ_COLLISION = 1;

    // ---------------------------------------------------------------
    // Reset values and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_CLK_SEL = 3'h0;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] SYNC_RST = 3'h2;
    localparam int DIV_W = 13;

    // Half bit period exponents: period is system clock over 2^(exp+1)
    localparam logic [3:0] HALF_EXP_SEL0 = 4'hC;
    localparam logic [3:0] HALF_EXP_SEL1 = 4'hA;
    localparam logic [3:0] HALF_EXP_SEL2 = 4'h9;
    localparam logic [3:0] HALF_EXP_SEL3 = 4'h7;
    localparam logic [3:0] HALF_EXP_SEL4 = 4'h5;
    localparam logic [3:0] HALF_EXP_SEL5 = 4'h4;

    // ---------------------------------------------------------------
    // Codes
    // ---------------------------------------------------------------
    localparam logic [2:0] CLK_SEL_EXT_SS = 3'h6;
    localparam logic [2:0] CLK_SEL_EXT_FREE = 3'h7;
    localparam logic [1:0] MODE_DUPLEX = 2'h0;
    localparam logic [1:0] MODE_TX_ONLY = 2'h1;
    localparam logic [1:0] MODE_RX_ONLY = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
    localparam logic [1:0] IF_MODE_GPIO = 2'h0;
    localparam logic [1:0] IF_MODE_SERIAL = 2'h1;
    localparam logic [1:0] IF_MODE_UART = 2'h2;

    typedef enum logic {ST_IDLE, ST_SHIFT} shift_state_t;

    // Shift configuration bundle
    typedef struct packed {
        logic sample_phase_sel;
        logic shift_edge_sel;
        logic bit_order_sel;
        logic [2:0] clk_sel;
        logic [1:0] transfer_mode;
    } shift_cfg_t;

endpackage : serial_port_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] stage_one;

    // Two flip-flop synchroniser, first stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stage_one <= INIT;
            q_out <= INIT;
        end else begin
            stage_one <= d_in;
            q_out <= stage_one;
        end
    end
endmodule : pin_sync

/* rtl/rate_divider.sv */
`timescale 1ns/10ps
module rate_divider
    import serial_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic restart_in,
    input wire logic run_in,
    input wire logic [3:0] half_exp_in,
    output logic mid_out,
    output logic end_out
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] half;
    logic [DIV_W-1:0] period_last;

    // Half period and last count of one bit period
    assign half = DIV_W'(1) << half_exp_in;
    assign period_last = DIV_W'((half << 1) - DIV_W'(1));
    assign mid_out = run_in && !restart_in && (count == DIV_W'(half - DIV_W'(1)));
    assign end_out = run_in && !restart_in && (count == period_last);

    // Bit period counter, restarted at the start of a byte
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count <= '0;
        end else if (restart_in || !run_in || end_out) begin
            count <= '0;
        end else begin
            count <= count + DIV_W'(1);
        end
    end
endmodule : rate_divider

/* rtl/serial_peripheral_shift_port.sv */
// Contract
// RULE1: Sample-phase 0 samples mid bit period, 1 samples at period end.
// RULE2: With external serial clock, sampling is always mid bit period.
// RULE3: Collision flag set by hardware, cleared only by software writing 0.
// RULE4: Clock codes 0 to 5 divide system clock by 2^13,11,10,8,6,5.
// RULE5: Code 6 external clock with slave select, code 7 without.
// RULE6: Output data changes on rising edge if shift-edge 0, else falling.
// RULE7: Bit-order 0 sends MSB first, 1 sends LSB first.
// RULE8: Transmit-loaded flag reads 0 when empty, set by data buffer write.
// RULE9: Writing start bit 1 begins shifting; hardware clears it when done.
// RULE10: Software must set start bit again for each further byte.
// RULE11: Transfer mode 0 duplex, 1 transmit only, 2 receive only, 3 reserved.
// RULE12: Receive-full set on completed byte, cleared by reading data buffer.
// RULE13: Receive-full also cleared when the serial port gets enabled.
// RULE14: Software reads each byte before the next completes to avoid collision.
// RULE15: One data buffer: write loads transmit byte, read returns received byte.
// RULE16: Interface mode 1 gives pins to the serial port; 0,2,3 do not.
// RULE17: Collision raised when a byte completes while receive-full still set.
// RULE18: One transfer is eight shift clock periods, one bit each way each.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module serial_peripheral_shift_port
    import serial_port_pkg::*;
#(
    parameter logic [3:0] SLOWEST_HALF_EXP = HALF_EXP_SEL0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    output logic irq_out,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_out,
    input wire logic ss_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out
);
    // ---------------------------------------------------------------
    // Registers and internal signals
    // ---------------------------------------------------------------
    shift_cfg_t cfg;
    shift_state_t state;
    logic collision_flag;
    logic tx_buffer_loaded_flag;
    logic start_shift_bit;
    logic rx_buffer_full_flag;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [1:0] if_mode;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [2:0] bit_cnt;
    logic ext_sampled;
    logic sck_prev;
    logic [2:0] pins_sync;
    logic sck_s;
    logic ss_n_s;
    logic sdi_s;
    logic sel_ctrl_one;
    logic sel_ctrl_two;
    logic sel_data;
    logic sel_if_mode;
    logic sel_irq_status;
    logic sel_irq_mask;
    logic port_enabled;
    logic ext_clk;
    logic rx_enabled;
    logic tx_enabled;
    logic ss_ok;
    logic ext_shift_edge;
    logic ext_sample_edge;
    logic div_mid;
    logic div_end;
    logic [3:0] half_exp;
    logic start_go;
    logic abort_now;
    logic sample_now;
    logic shift_now;
    logic done_now;
    logic enable_event;
    logic collide_now;
    logic [7:0] next_rx;
    logic [1:0] next_irq_status;

    // ---------------------------------------------------------------
    // Pin synchronisers and helpers
    // ---------------------------------------------------------------
    // Serial clock, slave select and data in cross into the bus clock
    pin_sync #(.WIDTH(3), .INIT(SYNC_RST)) u_pin_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in({sck_in, ss_n_in, sdi_in}),
        .q_out(pins_sync)
    );
    assign sck_s = pins_sync[2];
    assign ss_n_s = pins_sync[1];
    assign sdi_s = pins_sync[0];

    // Internal shift clock timing
    rate_divider u_rate_divider (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(start_go),
        .run_in((state == ST_SHIFT) && !ext_clk),
        .half_exp_in(half_exp),
        .mid_out(div_mid),
        .end_out(div_end)
    );

    // Clock select to half period exponent
    always_comb begin
        case (cfg.clk_sel) // see RULE4
            3'h0: half_exp = SLOWEST_HALF_EXP;
            3'h1: half_exp = HALF_EXP_SEL1;
            3'h2: half_exp = HALF_EXP_SEL2;
            3'h3: half_exp = HALF_EXP_SEL3;
            3'h4: half_exp = HALF_EXP_SEL4;
            default: half_exp = HALF_EXP_SEL5;
        endcase
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    always_comb begin
        sel_ctrl_one = 1'b0;
        sel_ctrl_two = 1'b0;
        sel_data = 1'b0;
        sel_if_mode = 1'b0;
        sel_irq_status = 1'b0;
        sel_irq_mask = 1'b0;
        if (addr_in == OFF_CTRL_ONE) begin
            sel_ctrl_one = 1'b1;
        end else if (addr_in == OFF_CTRL_TWO) begin
            sel_ctrl_two = 1'b1;
        end else if (addr_in == OFF_DATA) begin
            sel_data = 1'b1;
        end else if (addr_in == OFF_IF_MODE) begin
            sel_if_mode = 1'b1;
        end else if (addr_in == OFF_IRQ_STATUS) begin
            sel_irq_status = 1'b1;
        end else if (addr_in == OFF_IRQ_MASK) begin
            sel_irq_mask = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Shift control decisions
    // ---------------------------------------------------------------
    assign port_enabled = (if_mode == IF_MODE_SERIAL); // see RULE16
    assign ext_clk = (cfg.clk_sel == CLK_SEL_EXT_SS) || (cfg.clk_sel == CLK_SEL_EXT_FREE);
    assign rx_enabled = (cfg.transfer_mode != MODE_TX_ONLY); // see RULE11
    assign tx_enabled = (cfg.transfer_mode != MODE_RX_ONLY); // see RULE11
    assign ss_ok = (cfg.clk_sel == CLK_SEL_EXT_FREE) || !ss_n_s; // see RULE5
    assign ext_shift_edge = cfg.shift_edge_sel ? (sck_prev && !sck_s) : (!sck_prev && sck_s);
    assign ext_sample_edge = cfg.shift_edge_sel ? (!sck_prev && sck_s) : (sck_prev && !sck_s);
    assign start_go = (state == ST_IDLE) && start_shift_bit && port_enabled
                      && (cfg.transfer_mode != MODE_RESERVED); // see RULE9
    assign abort_now = (state == ST_SHIFT) && !port_enabled;
    assign enable_event = wr_in && sel_if_mode && !port_enabled
                          && (wdata_in[BIT_IF_MODE_LO +: 2] == IF_MODE_SERIAL);

    // External clock samples on the opposite edge, i.e. mid bit
    always_comb begin
        sample_now = 1'b0;
        shift_now = 1'b0;
        done_now = 1'b0;
        if (state == ST_SHIFT && port_enabled) begin
            if (ext_clk) begin
                sample_now = ext_sample_edge && ss_ok; // see RULE2
                done_now = sample_now && (bit_cnt == LAST_BIT); // see RULE18
                shift_now = !done_now && ext_shift_edge && ss_ok && ext_sampled;
            end else begin
                sample_now = cfg.sample_phase_sel ? div_end : div_mid; // see RULE1
                done_now = div_end && (bit_cnt == LAST_BIT); // see RULE18
                shift_now = !done_now && div_end;
            end
        end
    end

    // Received byte as it stands after this cycle's sample
    always_comb begin
        next_rx = rx_shift;
        if (sample_now) begin
            next_rx = cfg.bit_order_sel ? {sdi_s, rx_shift[7:1]} : {rx_shift[6:0], sdi_s};
        end
    end

    assign collide_now = done_now && rx_enabled && rx_buffer_full_flag
                         && !(rd_in && sel_data); // see RULE17
    assign next_irq_status = (irq_status & ((rd_in && sel_irq_status) ? RST_IRQ : 2'h3))
                             | {collide_now, done_now};

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    // Software settings of the shift engine
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg <= '0;
            if_mode <= IF_MODE_GPIO;
            irq_mask <= RST_IRQ;
        end else if (wr_in) begin
            if (sel_ctrl_one) begin
                cfg.sample_phase_sel <= wdata_in[BIT_SAMPLE_PHASE];
                cfg.clk_sel <= wdata_in[BIT_CLK_SEL_LO +: 3];
                cfg.shift_edge_sel <= wdata_in[BIT_SHIFT_EDGE];
                cfg.bit_order_sel <= wdata_in[BIT_BIT_ORDER];
            end
            if (sel_ctrl_two) begin
                cfg.transfer_mode <= wdata_in[BIT_MODE_LO +: 2];
            end
            if (sel_if_mode) begin
                if_mode <= wdata_in[BIT_IF_MODE_LO +: 2];
            end
            if (sel_irq_mask) begin
                irq_mask <= wdata_in[1:0];
            end
        end
    end

    // Collision flag, hardware set wins over software clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            collision_flag <= 1'b0;
        end else if (collide_now) begin
            collision_flag <= 1'b1; // see RULE3
        end else if (wr_in && sel_ctrl_one && !wdata_in[BIT_COLLISION]) begin
            collision_flag <= 1'b0; // see RULE3
        end
    end

    // Start bit, cleared when the byte is finished or the port drops during a transfer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            start_shift_bit <= 1'b0;
        end else if (wr_in && sel_ctrl_two && wdata_in[BIT_START_SHIFT]) begin
            start_shift_bit <= 1'b1; // see RULE9
        end else if (done_now || abort_now) begin
            start_shift_bit <= 1'b0; // see RULE9 RULE10
        end
    end

    // Transmit byte and its loaded flag
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_data <= RST_BYTE;
            tx_buffer_loaded_flag <= 1'b0;
        end else if (wr_in && sel_data) begin
            tx_data <= wdata_in; // see RULE15
            tx_buffer_loaded_flag <= 1'b1; // see RULE8
        end else if (start_go) begin
            tx_buffer_loaded_flag <= 1'b0; // see RULE8
        end
    end

    // Received byte and its full flag; completion wins over read
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_data <= RST_BYTE;
            rx_buffer_full_flag <= 1'b0;
        end else if (done_now && rx_enabled) begin
            rx_data <= next_rx; // see RULE15
            rx_buffer_full_flag <= 1'b1; // see RULE12
        end else if ((rd_in && sel_data) || enable_event) begin
            rx_buffer_full_flag <= 1'b0; // see RULE12 RULE13
        end
    end

    // Sticky event bits, read clears, new event wins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_status <= RST_IRQ;
            irq_out <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_out <= |(next_irq_status & irq_mask);
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= RST_BYTE;
        end else if (!rd_in) begin
            rdata_out <= RST_BYTE;
        end else if (sel_ctrl_one) begin
            rdata_out <= {cfg.sample_phase_sel, collision_flag, cfg.clk_sel,
                          cfg.shift_edge_sel, cfg.bit_order_sel, tx_buffer_loaded_flag};
        end else if (sel_ctrl_two) begin
            rdata_out <= {start_shift_bit, 4'h0, cfg.transfer_mode, rx_buffer_full_flag};
        end else if (sel_data) begin
            rdata_out <= rx_data;
        end else if (sel_if_mode) begin
            rdata_out <= {6'h00, if_mode};
        end else if (sel_irq_status) begin
            rdata_out <= {6'h00, irq_status};
        end else if (sel_irq_mask) begin
            rdata_out <= {6'h00, irq_mask};
        end else begin
            rdata_out <= RST_BYTE;
        end
    end

    // ---------------------------------------------------------------
    // Shift engine
    // ---------------------------------------------------------------
    // Transfer sequencing
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            ext_sampled <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    bit_cnt <= 3'h0;
                    ext_sampled <= 1'b0;
                    if (start_go) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (done_now || abort_now) begin
                        state <= ST_IDLE;
                    end else if (ext_clk ? sample_now : div_end) begin
                        bit_cnt <= bit_cnt + 3'h1; // see RULE18
                    end
                    if (sample_now) begin
                        ext_sampled <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Shift registers and data out; bit order picks the end used
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_shift <= RST_BYTE;
            rx_shift <= RST_BYTE;
            sdo_out <= 1'b0;
        end else begin
            rx_shift <= next_rx;
            if (start_go) begin
                tx_shift <= tx_data;
                sdo_out <= cfg.bit_order_sel ? tx_data[0] : tx_data[7]; // see RULE7
            end else if (shift_now) begin
                tx_shift <= cfg.bit_order_sel ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};
                sdo_out <= cfg.bit_order_sel ? tx_shift[1] : tx_shift[6]; // see RULE6 RULE7
            end
        end
    end

    // Serial clock out: shift edge at bit start, idle level at mid bit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sck_out <= 1'b0;
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_s;
            if (start_go || (shift_now && !ext_clk)) begin
                sck_out <= !cfg.shift_edge_sel; // see RULE6
            end else if (state == ST_IDLE || div_mid) begin
                sck_out <= cfg.shift_edge_sel;
            end
        end
    end

    // Pin drive enables
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sck_oe_out <= 1'b0;
            sdo_oe_out <= 1'b0;
        end else begin
            sck_oe_out <= port_enabled && !ext_clk; // see RULE5
            sdo_oe_out <= port_enabled && tx_enabled && (!ext_clk || ss_ok); // see RULE5 RULE11
        end
    end

endmodule : serial_peripheral_shift_port

/* tb/serial_port_props.sv */
`timescale 1ns/10ps
module serial_port_props
    import serial_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic irq_out,
    input wire logic sck_oe_out,
    input wire logic sdo_oe_out
);
    logic [6:0] cfg;
    logic rd_one;
    logic coll;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Shadow of mode and clock fields
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg <= '0;
        end else if (wr_in && addr_in == OFF_IF_MODE) begin
            cfg[6:5] <= wdata_in[1:0];
        end else if (wr_in && addr_in == OFF_CTRL_ONE) begin
            cfg[4:2] <= wdata_in[5:3];
        end else if (wr_in && addr_in == OFF_CTRL_TWO) begin
            cfg[1:0] <= wdata_in[2:1];
        end
    end
    // Collision seen stays until a write of 0
    always_ff @(posedge clk_in) begin
        rd_one <= rst_n_in && rd_in && addr_in == OFF_CTRL_ONE;
        if (!rst_n_in || (wr_in && addr_in == OFF_CTRL_ONE && !wdata_in[BIT_COLLISION])) begin
            coll <= 1'b0;
        end else if (rd_one && rdata_out[BIT_COLLISION]) begin
            coll <= 1'b1;
        end
    end
    a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside a read");
    a_tx_loaded_set: assert property ((wr_in && addr_in == OFF_DATA) ##1
        (rd_in && addr_in == OFF_CTRL_ONE) |=> rdata_out[BIT_TX_LOADED]) else $error("no tx flag");
    a_rx_full_clear: assert property ((rd_in && addr_in == OFF_DATA) ##1
        (rd_in && addr_in == OFF_CTRL_TWO) |=> !rdata_out[BIT_RX_FULL]) else $error("rx flag kept");
    a_coll_sticky: assert property (rd_one && coll |-> rdata_out[BIT_COLLISION])
        else $error("collision lost");
    a_port_off: assert property (wr_in && addr_in == OFF_IF_MODE && wdata_in[1:0] != 2'h1
        |=> ##1 !sck_oe_out && !sdo_oe_out) else $error("pins driven while off");
    a_rx_only_quiet: assert property (cfg[1:0] == MODE_RX_ONLY && $stable(cfg)
        |-> !sdo_oe_out) else $error("data driven in receive mode");
    a_ext_clk_quiet: assert property (cfg[4:3] == 2'h3 && $stable(cfg) |-> !sck_oe_out)
        else $error("clock driven in external mode");
    a_int_clk_drive: assert property (cfg[6:5] == IF_MODE_SERIAL && cfg[4:2] <= 3'h5
        && $stable(cfg) |-> sck_oe_out) else $error("internal clock not driven");
endmodule : serial_port_props

bind serial_peripheral_shift_port serial_port_props serial_port_props_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .sck_oe_out(sck_oe_out), .sdo_oe_out(sdo_oe_out));

/* tb/serial_peer.sv */
`timescale 1ns/10ps
module serial_peer (
    input wire logic sck_in,
    input wire logic sdo_in,
    input wire logic idle_lvl_in,
    input wire logic lsb_first_in,
    input wire logic arm_in,
    input wire logic [7:0] tx_in,
    output logic sdi_out,
    output logic [7:0] rx_out
);
    int n = 8;
    initial sdi_out = 1'b0;
    initial rx_out = 8'h00;
    // New frame: line inverts the stale bit until the first shift edge
    always @(posedge arm_in) begin
        n = 0;
        sdi_out = ~sdi_out;
    end
    // Leading edge drives a bit; trailing edge reads one
    always @(sck_in) begin
        if (n < 8 && sck_in !== idle_lvl_in) begin
            sdi_out = lsb_first_in ? tx_in[n] : tx_in[7 - n];
        end else if (n < 8) begin
            rx_out = lsb_first_in ? {sdo_in, rx_out[7:1]} : {rx_out[6:0], sdo_in};
            n = n + 1;
        end
    end
endmodule : serial_peer

/* tb/tb.sv */
`timescale 1ns/10ps
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module tb
    import serial_port_pkg::*;
;
    localparam logic [3:0] SLOW_EXP = 4'h2;
    logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, arm = 1'b0, edge_cfg = 1'b0;
    logic lsb_cfg = 1'b0, prev_sck = 1'b0, sck, sck_oe, sdo, sdo_oe, sdi, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, peer_tx = 8'h00, rdata, peer_rx;
    int tests_run = 0, miscompares = 0, cyc = 0, last_lead = 0, period = 0, leads = 0, c;
    int per [6] = '{2 ** (SLOW_EXP + 1), 2048, 1024, 256, 64, 32};
    serial_peripheral_shift_port #(.SLOWEST_HALF_EXP(SLOW_EXP)) serial_peripheral_shift_port_inst (
        .clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
        .rd_in(rd_s), .rdata_out(rdata), .irq_out(irq), .sck_in(1'b0), .sck_out(sck),
        .sck_oe_out(sck_oe), .ss_n_in(1'b1), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe));
    serial_peer serial_peer_inst (.sck_in(sck), .sdo_in(sdo), .idle_lvl_in(edge_cfg),
        .lsb_first_in(lsb_cfg), .arm_in(arm), .tx_in(peer_tx), .sdi_out(sdi), .rx_out(peer_rx));
    always #5 clk = ~clk;
    // Leading shift edges: count and spacing
    always @(posedge clk) begin
        cyc <= cyc + 1;
        prev_sck <= sck;
        if (sck_oe && sck !== prev_sck && sck !== edge_cfg) begin
            leads <= leads + 1;
            last_lead <= cyc;
            period <= cyc - last_lead;
        end
    end
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        wr_s <= w;
        rd_s <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr
    // Read data comes a cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        fork
            #1 `CHK("read data", exp, rdata)
        join_none
    endtask : rd
    task automatic idle();
        bus(1'b0, 1'b0, addr, wdata);
    endtask : idle
    // Start one byte and wait for done
    task automatic xfer(input logic [7:0] cfg, input logic [1:0] mode, input logic [7:0] tx,
                        input logic [7:0] ptx);
        int i;
        edge_cfg = cfg[BIT_SHIFT_EDGE];
        lsb_cfg = cfg[BIT_BIT_ORDER];
        peer_tx = ptx;
        wr(OFF_CTRL_ONE, cfg);
        wr(OFF_CTRL_TWO, {5'h00, mode, 1'b0});
        wr(OFF_DATA, tx);
        rd(OFF_CTRL_ONE, cfg | 8'h01);
        arm <= 1'b1;
        leads <= 0;
        wr(OFF_CTRL_TWO, {5'h10, mode, 1'b0});
        arm <= 1'b0;
        idle();
        for (i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge clk);
        `CHK("done irq", 1'b1, irq)
    endtask : xfer
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // Watchdog
    initial begin
        #600000;
        miscompares++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (c = 5; c < 12; c++) rd(8'(c), 8'h00);
        wr(OFF_IF_MODE, 8'h01);
        wr(OFF_IRQ_MASK, 8'h03);
        for (c = 0; c < 6; c++) begin
            xfer({2'h0, 3'(c), 3'h0}, MODE_DUPLEX, 8'hA5, 8'h3C);
            `CHK("bit period", per[c], period)
            `CHK("edges", 8, leads)
            `CHK("peer byte", 8'hA5, peer_rx)
            rd(OFF_IRQ_STATUS, 8'h01);
            rd(OFF_CTRL_TWO, 8'h01);
            rd(OFF_DATA, 8'h3C);
            rd(OFF_CTRL_TWO, 8'h00);
        end
        xfer(8'hAE, MODE_DUPLEX, 8'h96, 8'h4D);
        `CHK("peer byte", 8'h96, peer_rx)
        `CHK("sck idle", 1'b1, sck)
        rd(OFF_IRQ_STATUS, 8'h01);
        xfer(8'hAE, MODE_DUPLEX, 8'h69, 8'h22);
        wr(OFF_IRQ_MASK, 8'h00);
        repeat (3) idle();
        `CHK("masked irq", 1'b0, irq)
        rd(OFF_IRQ_STATUS, 8'h03);
        wr(OFF_IRQ_MASK, 8'h03);
        rd(OFF_CTRL_ONE, 8'hEE);
        wr(OFF_CTRL_ONE, 8'hEE);
        rd(OFF_CTRL_ONE, 8'hEE);
        wr(OFF_CTRL_ONE, 8'hAE);
        rd(OFF_CTRL_ONE, 8'hAE);
        rd(OFF_DATA, 8'h22);
        xfer(8'h28, MODE_TX_ONLY, 8'h5A, 8'hFF);
        `CHK("peer byte", 8'h5A, peer_rx)
        rd(OFF_CTRL_TWO, 8'h02);
        rd(OFF_IRQ_STATUS, 8'h01);
        xfer(8'h28, MODE_RX_ONLY, 8'h00, 8'hC3);
        rd(OFF_CTRL_TWO, 8'h05);
        rd(OFF_IRQ_STATUS, 8'h01);
        wr(OFF_IF_MODE, 8'h00);
        wr(OFF_IF_MODE, 8'h01);
        rd(OFF_CTRL_TWO, 8'h04);
        rd(OFF_DATA, 8'hC3);
        wr(OFF_CTRL_TWO, 8'h86);
        repeat (40) idle();
        rd(OFF_CTRL_TWO, 8'h86);
        for (c = 6; c < 8; c++) begin
            wr(OFF_CTRL_ONE, {2'h0, 3'(c), 3'h0});
            repeat (3) idle();
            `CHK("sck drive", 1'b0, sck_oe)
            `CHK("sdo drive", c == 7, sdo_oe)
        end
        wr(8'h0B, 8'hFF);
        rd(8'h0B, 8'h00);
        repeat (2) idle();
        wrap_up();
    end
endmodule : tb
